// file: inc/ipx_pkg.sv
// Package of constants and types for the pin control and peripheral pin router.
package ipx_pkg;

	// Register port addresses of the plain register bus.
	localparam logic [3:0] ADDR_PORT_DATA      = 4'h0;
	localparam logic [3:0] ADDR_PORT_DIRECTION = 4'h1;
	localparam logic [3:0] ADDR_PIN_FEATURE    = 4'h2;
	localparam logic [3:0] ADDR_GRANT_STATUS   = 4'h3;
	localparam logic [3:0] ADDR_PIN_STATE      = 4'h4;

	// Field layout of the pin feature register write word.
	localparam int FEAT_CODE_LSB = 0;
	localparam int FEAT_CODE_W   = 3;
	localparam int FEAT_SIDE_BIT = 3;
	localparam int FEAT_ADDR_LSB = 4;
	localparam int FEAT_ADDR_W   = 3;

	// Reset values: every pin a digital input with buffer on and no pull.
	localparam logic [7:0] PORT_DATA_RST = 8'h00;
	localparam logic [7:0] PORT_DIR_RST  = 8'hff;

	// Number of peripheral router columns, highest priority first.
	localparam int NUM_PERIPH = 6;

	// Pin feature codes.
	typedef enum logic [2:0] {
		IPX_FEAT_OUT_NORMAL = 3'h0,
		IPX_FEAT_OUT_HIGH   = 3'h1,
		IPX_FEAT_IN_NOPULL  = 3'h2,
		IPX_FEAT_IN_PULLUP  = 3'h3,
		IPX_FEAT_IN_PULLDN  = 3'h4,
		IPX_FEAT_IN_OFF     = 3'h5
	} ipx_feat_t;

endpackage : ipx_pkg

// file: rtl/ipx_pin_router.sv
// Per-pin IO control registers and priority peripheral pin router for one port.
// The router is fully registered: grants, ownership and analog switches change one
// enabled cycle after the enables that cause them, so no pin flips owners mid-cycle.
// Pad levels are synchronised before use, so a peripheral sees a pad change two
// enabled cycles after it happens.
// The crystal oscillator outranks every digital column only in digital mode; in analog mode it
// keeps the converter reference off the analog switches.
// Analog use never touches the digital registers: software sets direction and
// features of an analog pin itself before it enables the converter or comparator.
// While clk_en is low every register, the synchronisers included, holds its value.
// Feature settings cannot be read back; a read of the feature address returns zero.
//
// Local design decisions: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps

module ipx_pin_router
	import ipx_pkg::*;
#(
	parameter int                  NUM_PINS    = 8,
	parameter logic [7:0]          SER_RX_PIN  = 8'h06,
	parameter logic [7:0]          SER_TX_PIN  = 8'h05,
	parameter logic [7:0]          SLV_DO_PIN  = 8'h04,
	parameter logic [7:0]          SLV_CS_PIN  = 8'h05,
	// Pin set of each digital peripheral column, index 0 highest priority.
	parameter logic [NUM_PERIPH*8-1:0] PERIPH_PINS = {
		8'h40, 8'h60, 8'h3c, 8'h3c, 8'h1c, 8'h02},
	// Forced output mask of each column; bits outside the set are ignored.
	parameter logic [NUM_PERIPH*8-1:0] PERIPH_OUTS = {
		8'h48, 8'h60, 8'h48, 8'h10, 8'h0c, 8'h00}
) (
	// Clock, enable and reset.
	input  wire logic                  clock,
	input  wire logic                  clk_en,
	input  wire logic                  rst_n,
	// Register port.
	input  wire logic [3:0]            reg_addr,
	input  wire logic [7:0]            reg_wdata,
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	output logic      [7:0]            reg_rdata,
	// Peripheral requests and signals.
	input  wire logic [NUM_PERIPH-1:0] periph_en,
	input  wire logic [NUM_PERIPH*8-1:0] periph_do,
	output logic      [NUM_PERIPH*8-1:0] periph_di,
	input  wire logic                  xosc_en,
	input  wire logic                  xosc_analog,
	input  wire logic [7:0]            xosc_pins,
	input  wire logic                  conv_en,
	input  wire logic                  comp_en,
	input  wire logic [2:0]            converter_channel_select,
	input  wire logic [2:0]            converter_reference_select,
	input  wire logic                  converter_reference_ext,
	output logic      [7:0]            analog_connect,
	// Default routed serial links.
	input  wire logic                  ser_txd,
	output logic                       ser_rxd,
	// Pads.
	input  wire logic [7:0]            pad_in,
	output logic      [7:0]            pad_out,
	output logic      [7:0]            pad_oe,
	output logic      [7:0]            pad_ie,
	output logic      [7:0]            pad_high_drive,
	output logic      [7:0]            pad_pull_up,
	output logic      [7:0]            pad_pull_down
);

	// Register state.
	logic [7:0]      port_data_reg_q;
	logic [7:0]      port_direction_reg_q;
	logic [7:0]      in_off_q;
	logic [7:0]      pull_up_q;
	logic [7:0]      pull_dn_q;
	logic [7:0]      high_drv_q;
	logic [7:0]      pin_sync1_q;
	logic [7:0]      pin_sync2_q;
	logic [7:0]      own_q;
	logic [7:0]      own_dir_q;
	logic [7:0]      own_do_q;
	logic [7:0]      analog_q;
	logic [NUM_PERIPH-1:0] grant_q;
	logic [NUM_PERIPH-1:0] grant_d;
	logic [7:0]      own_d;
	logic [7:0]      own_dir_d;
	logic [7:0]      own_do_d;
	logic [7:0]      analog_d;
	logic [2:0]      feat_code;
	logic [2:0]      feat_pin;
	logic            feat_wr;

	// Decodes a pin index into a one-hot mask.
	function automatic logic [7:0] pin_mask(input logic [2:0] idx);
		pin_mask = 8'h01 << idx;
	endfunction : pin_mask

	assign feat_code = reg_wdata[FEAT_CODE_LSB +: FEAT_CODE_W];
	assign feat_pin  = reg_wdata[FEAT_ADDR_LSB +: FEAT_ADDR_W];
	assign feat_wr   = reg_wr && (reg_addr == ADDR_PIN_FEATURE);

	// Port data and direction are written as a whole port.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			port_data_reg_q      <= PORT_DATA_RST;
			port_direction_reg_q <= PORT_DIR_RST;
		end else if (clk_en && reg_wr) begin
			if (reg_addr == ADDR_PORT_DATA) begin
				port_data_reg_q <= reg_wdata;
			end
			if (reg_addr == ADDR_PORT_DIRECTION) begin
				port_direction_reg_q <= reg_wdata;
			end
		end
	end

	// Pin feature writes update one addressed pin; the side bit picks output or input.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			in_off_q   <= 8'h00;
			pull_up_q  <= 8'h00;
			pull_dn_q  <= 8'h00;
			high_drv_q <= 8'h00;
		end else if (clk_en && feat_wr) begin
			if (reg_wdata[FEAT_SIDE_BIT]) begin
				// Output side feature.
				high_drv_q[feat_pin] <= (feat_code == IPX_FEAT_OUT_HIGH);
			end else begin
				// Input side feature.
				in_off_q[feat_pin]  <= (feat_code == IPX_FEAT_IN_OFF);
				pull_up_q[feat_pin] <= (feat_code == IPX_FEAT_IN_PULLUP);
				pull_dn_q[feat_pin] <= (feat_code == IPX_FEAT_IN_PULLDN);
			end
		end
	end

	// Pad inputs pass two flip-flops before any logic reads them.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pin_sync1_q <= 8'h00;
			pin_sync2_q <= 8'h00;
		end else if (clk_en) begin
			pin_sync1_q <= pad_in;
			pin_sync2_q <= pin_sync1_q;
		end
	end

	// Priority arbitration: a column wins only if its whole set is free.
	always_comb begin
		logic [7:0] taken;
		logic [7:0] set;
		logic [7:0] ana;
		taken     = 8'h00;
		set       = 8'h00;
		grant_d   = '0;
		own_d     = 8'h00;
		own_dir_d = 8'h00;
		own_do_d  = 8'h00;
		ana       = 8'h00;
		// Crystal oscillator has top priority in digital mode; in analog mode it closes its pins' analog switches and blocks the converter reference.
		if (xosc_en) begin
			if (xosc_analog) begin
				ana = xosc_pins;
			end else begin
				taken = xosc_pins;
				own_d = xosc_pins;
			end
		end
		for (int i = 0; i < NUM_PERIPH; i++) begin
			set = PERIPH_PINS[i*8 +: 8];
			if (periph_en[i] && ((set & taken) == 8'h00)) begin
				grant_d[i] = 1'b1;
				taken      = taken | set;
				own_d      = own_d | set;
				own_dir_d  = own_dir_d | (set & PERIPH_OUTS[i*8 +: 8]);
				own_do_d   = own_do_d | (set & PERIPH_OUTS[i*8 +: 8] & periph_do[i*8 +: 8]);
			end
		end
		// Converter and comparator share the select fields; only the reference yields to an analog xosc.
		if (conv_en || comp_en) begin
			ana = ana | pin_mask(converter_channel_select);
			if (converter_reference_ext && !(xosc_en && xosc_analog)) begin
				ana = ana | pin_mask(converter_reference_select);
			end
		end
		analog_d = ana;
	end

	// Router state is refreshed every enabled cycle from current enables.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			grant_q   <= '0;
			own_q     <= 8'h00;
			own_dir_q <= 8'h00;
			own_do_q  <= 8'h00;
			analog_q  <= 8'h00;
		end else if (clk_en) begin
			grant_q   <= grant_d;
			own_q     <= own_d;
			own_dir_q <= own_dir_d;
			own_do_q  <= own_do_d;
			analog_q  <= analog_d;
		end
	end

	// Pad drive: GPIO registers by default, router when a peripheral owns the pin.
	always_comb begin
		logic [7:0] gp_out;
		logic [7:0] oe;
		gp_out = port_data_reg_q;
		oe     = ~port_direction_reg_q;
		gp_out[SER_TX_PIN[2:0]] = port_data_reg_q[SER_TX_PIN[2:0]] & ser_txd;
		for (int p = 0; p < 8; p++) begin
			if (own_q[p]) begin
				oe[p]     = own_dir_q[p];
				gp_out[p] = own_do_q[p];
			end
		end
		// Slave data out only drives while the chip select pin is low.
		if (own_q[SLV_DO_PIN[2:0]] && pin_sync2_q[SLV_CS_PIN[2:0]]) begin
			oe[SLV_DO_PIN[2:0]] = 1'b0;
		end
		pad_out        = gp_out;
		pad_oe         = oe;
		pad_ie         = ~in_off_q;
		pad_high_drive = high_drv_q;
		pad_pull_up    = pull_up_q & ~in_off_q;
		pad_pull_down  = pull_dn_q & ~in_off_q;
		analog_connect = analog_q;
	end

	// Input distribution; dual-listed inputs share the same synchronised level.
	always_comb begin
		for (int i = 0; i < NUM_PERIPH; i++) begin
			periph_di[i*8 +: 8] = pin_sync2_q & PERIPH_PINS[i*8 +: 8] & {8{grant_q[i]}};
		end
		ser_rxd = port_direction_reg_q[SER_RX_PIN[2:0]] ? pin_sync2_q[SER_RX_PIN[2:0]]
			: 1'b1;
	end

	// Registered read data, valid the cycle after the strobe.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else if (clk_en && reg_rd) begin
			unique case (reg_addr)
				ADDR_PORT_DATA:      reg_rdata <= port_direction_reg_q & pin_sync2_q
					| ~port_direction_reg_q & port_data_reg_q;
				ADDR_PORT_DIRECTION: reg_rdata <= port_direction_reg_q;
				ADDR_GRANT_STATUS:   reg_rdata <= 8'(grant_q);
				ADDR_PIN_STATE:      reg_rdata <= own_q;
				default:             reg_rdata <= 8'h00;
			endcase
		end
	end

	// Assertions.
	// Reset and default routing.
	AST_RESET_INPUTS: assert property (@(posedge clock) $rose(rst_n) |-> pad_oe == 8'h00)
		else $error("pins not inputs after reset");
	AST_RESET_REGS: assert property (@(posedge clock) $rose(rst_n) |->
		port_direction_reg_q == PORT_DIR_RST && pad_ie == 8'hff && analog_connect == 8'h00)
		else $error("pin state not reset");
	AST_DEFAULT_GPIO: assert property (@(posedge clock) disable iff (!rst_n)
		own_q == 8'h00 && !reg_wr |-> pad_oe == ~port_direction_reg_q)
		else $error("default routing not from direction register");
	AST_NO_REQUEST: assert property (@(posedge clock) disable iff (!rst_n)
		clk_en && periph_en == '0 && !xosc_en |=> own_q == 8'h00 && grant_q == '0)
		else $error("pins owned without a request");

	// Whole-port and single-pin register writes.
	AST_DIR_WRITE: assert property (@(posedge clock) disable iff (!rst_n)
		clk_en && reg_wr && reg_addr == ADDR_PORT_DIRECTION |=>
		port_direction_reg_q == $past(reg_wdata))
		else $error("direction write lost");
	AST_DATA_WRITE: assert property (@(posedge clock) disable iff (!rst_n)
		clk_en && reg_wr && reg_addr == ADDR_PORT_DATA |=>
		port_data_reg_q == $past(reg_wdata))
		else $error("data write lost");
	AST_FEAT_OUT_PIN: assert property (@(posedge clock) disable iff (!rst_n)
		clk_en && feat_wr |=>
		((high_drv_q ^ $past(high_drv_q)) & ~pin_mask($past(feat_pin))) == 8'h00)
		else $error("feature write changed the drive of another pin");
	AST_FEAT_IN_PIN: assert property (@(posedge clock) disable iff (!rst_n)
		clk_en && feat_wr |=>
		(((pull_up_q ^ $past(pull_up_q)) | (pull_dn_q ^ $past(pull_dn_q))
		| (in_off_q ^ $past(in_off_q))) & ~pin_mask($past(feat_pin))) == 8'h00)
		else $error("feature write changed the input setting of another pin");
	AST_HIGH_DRIVE: assert property (@(posedge clock) disable iff (!rst_n)
		clk_en && feat_wr && reg_wdata[FEAT_SIDE_BIT] |=>
		high_drv_q[$past(feat_pin)] == ($past(feat_code) == IPX_FEAT_OUT_HIGH))
		else $error("drive strength not applied");
	AST_PULL_EXCL: assert property (@(posedge clock) disable iff (!rst_n)
		(pad_pull_up & pad_pull_down) == 8'h00)
		else $error("both pulls on");
	AST_FREEZE_REGS: assert property (@(posedge clock) disable iff (!rst_n)
		!clk_en |=> $stable(port_data_reg_q) && $stable(port_direction_reg_q)
		&& $stable(high_drv_q) && $stable(pull_up_q))
		else $error("registers moved with clock enable low");

	// Router grants and pin ownership.
	AST_GRANT_NEXT: assert property (@(posedge clock) disable iff (!rst_n)
		clk_en |=> grant_q == $past(grant_d))
		else $error("grant not refreshed");
	AST_FREEZE_ROUTER: assert property (@(posedge clock) disable iff (!rst_n)
		!clk_en |=> $stable(grant_q) && $stable(own_q) && $stable(analog_q))
		else $error("router moved with clock enable low");
	AST_ALL_OR_NONE: assert property (@(posedge clock) disable iff (!rst_n)
		grant_q[1] |-> (own_q & PERIPH_PINS[15:8]) == PERIPH_PINS[15:8])
		else $error("partial grant");
	AST_PRIORITY: assert property (@(posedge clock) disable iff (!rst_n)
		grant_q[1] && (PERIPH_PINS[15:8] & PERIPH_PINS[23:16]) != 8'h00 |-> !grant_q[2])
		else $error("lower priority took pins");
	AST_OWNED_DIR: assert property (@(posedge clock) disable iff (!rst_n)
		(pad_oe & own_q & ~pin_mask(SLV_DO_PIN[2:0]))
		== (own_dir_q & own_q & ~pin_mask(SLV_DO_PIN[2:0])))
		else $error("owned pin direction not from router");
	AST_XOSC_DIGITAL: assert property (@(posedge clock) disable iff (!rst_n)
		clk_en && xosc_en && !xosc_analog |=>
		(own_q & $past(xosc_pins)) == $past(xosc_pins))
		else $error("oscillator pins not taken");
	AST_SLAVE_DO: assert property (@(posedge clock) disable iff (!rst_n)
		pin_sync2_q[SLV_CS_PIN[2:0]] && own_q[SLV_DO_PIN[2:0]] |-> !pad_oe[SLV_DO_PIN[2:0]])
		else $error("slave data out driven while deselected");

	// Default serial links.
	AST_SER_TX_AND: assert property (@(posedge clock) disable iff (!rst_n)
		!own_q[SER_TX_PIN[2:0]] |->
		pad_out[SER_TX_PIN[2:0]] == (port_data_reg_q[SER_TX_PIN[2:0]] & ser_txd))
		else $error("transmit pin not data AND transmit");
	AST_SER_RX_IN: assert property (@(posedge clock) disable iff (!rst_n)
		port_direction_reg_q[SER_RX_PIN[2:0]] |-> ser_rxd == pin_sync2_q[SER_RX_PIN[2:0]])
		else $error("receive input not fed from input pin");
	AST_SER_RX_IDLE: assert property (@(posedge clock) disable iff (!rst_n)
		!port_direction_reg_q[SER_RX_PIN[2:0]] |-> ser_rxd)
		else $error("receive input not idle with output pin");

	// Analog switches.
	AST_ANALOG_SEL: assert property (@(posedge clock) disable iff (!rst_n)
		clk_en && conv_en ##1 1'b1 |-> analog_connect[$past(converter_channel_select)])
		else $error("selected channel not connected");
	AST_ANALOG_IDLE: assert property (@(posedge clock) disable iff (!rst_n)
		clk_en && !xosc_en && !conv_en && !comp_en |=> analog_connect == 8'h00)
		else $error("analog switch closed without a request");
	AST_DIGITAL_KEPT: assert property (@(posedge clock) disable iff (!rst_n)
		!reg_wr && (conv_en || comp_en) |=>
		$stable(port_direction_reg_q) && $stable(port_data_reg_q))
		else $error("analog enable changed digital settings");

	// Cover properties of the main scenarios.
	COV_GRANT: cover property (@(posedge clock) disable iff (!rst_n) grant_q[0]);
	COV_BLOCKED: cover property (@(posedge clock) disable iff (!rst_n)
		periph_en[1] && !grant_q[1] ##1 grant_q[1]);
	COV_ANALOG: cover property (@(posedge clock) disable iff (!rst_n) analog_connect != 8'h00);
	COV_FEAT: cover property (@(posedge clock) disable iff (!rst_n) feat_wr && clk_en);
	COV_XOSC: cover property (@(posedge clock) disable iff (!rst_n) xosc_en && own_q != 8'h00);

endmodule : ipx_pin_router

// file: verif/ipx_pad_model.sv
// Pad model of the outside pins seen by the pin router.
`timescale 1ns/1ps

module ipx_pad_model (
	// Pad side of the router.
	input  wire logic [7:0] pad_out,
	input  wire logic [7:0] pad_oe,
	input  wire logic [7:0] pad_pull_up,
	input  wire logic [7:0] pad_pull_down,
	// Level that outside circuits put on undriven pins.
	input  wire logic [7:0] ext_lvl,
	output logic      [7:0] pad_in
);
	// A driven pin follows its driver, else its pull, else the outside level.
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			pad_in[i] = pad_oe[i] ? pad_out[i] : pad_pull_up[i] | (~pad_pull_down[i] & ext_lvl[i]);
		end
	end
endmodule : ipx_pad_model

// file: verif/ipx_pin_router_test.sv
// Self-checking testbench of the pin router with its pad model.
`timescale 1ns/1ps

module ipx_pin_router_test
	import ipx_pkg::*;
;
	localparam logic [47:0] PINS = {8'h40, 8'h60, 8'h3c, 8'h3c, 8'h1c, 8'h02};
	localparam logic [47:0] OUTS = {8'h48, 8'h60, 8'h48, 8'h10, 8'h0c, 8'h00};
	localparam logic [5:0] EN_CASE [6] = '{6'h06, 6'h0c, 6'h12, 6'h14, 6'h20, 6'h01};
	logic        clock = 1'b0, clk_en = 1'b1, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [3:0]  reg_addr = 4'h0;
	logic [7:0]  reg_wdata = 8'h00, ext_lvl = 8'h00, xosc_pins = 8'h00;
	logic [7:0]  reg_rdata, analog_connect, pad_in, pad_out, pad_oe, pad_ie;
	logic [7:0]  pad_high_drive, pad_pull_up, pad_pull_down;
	logic [5:0]  periph_en = 6'h00;
	logic [47:0] periph_do = 48'h0, periph_di;
	logic        xosc_en = 1'b0, xosc_analog = 1'b0, conv_en = 1'b0, comp_en = 1'b0;
	logic        converter_reference_ext = 1'b0, ser_txd = 1'b1, ser_rxd;
	logic [2:0]  converter_channel_select = 3'h0, converter_reference_select = 3'h0;
	int          errors = 0, comparisons = 0, seed = 81656;
	// Behavioural model of the port registers.
	logic [7:0]  m_dir = 8'hd0, m_data, m_hd = 8'h00, m_pu = 8'h00, m_pd = 8'h00, m_ie = 8'hff;

	ipx_pin_router #(.PERIPH_PINS(PINS), .PERIPH_OUTS(OUTS)) i_ipx_pin_router (
		.clock, .clk_en, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.periph_en, .periph_do, .periph_di, .xosc_en, .xosc_analog, .xosc_pins,
		.conv_en, .comp_en, .converter_channel_select, .converter_reference_select,
		.converter_reference_ext, .analog_connect, .ser_txd, .ser_rxd, .pad_in, .pad_out,
		.pad_oe, .pad_ie, .pad_high_drive, .pad_pull_up, .pad_pull_down);
	ipx_pad_model i_ipx_pad_model (.pad_out, .pad_oe, .pad_pull_up, .pad_pull_down,
		.ext_lvl, .pad_in);

	// Clock of 5 ns period.
	always #2.5 clock = ~clock;

	// Compare one value and count it.
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// One write cycle on the register port.
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask : wr

	// One read cycle; data are looked at in the cycle after the strobe.
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1;
		check(reg_rdata, e);
	endtask : rd

	// Let n edges pass and step off the edge.
	task automatic settle(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : settle

	// Print the counts and the verdict, then stop.
	task automatic results;
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : results

	// Watchdog against a hang.
	initial begin
		#50000;
		errors++;
		results();
	end

	// Main sequence.
	initial begin
		logic [7:0] taken, oe_x, dout;
		logic [5:0] g;
		int p;
		logic [2:0] code;
		repeat (5) @(posedge clock);
		rst_n <= 1'b1;
		settle(1);
		check(pad_oe, 8'h00);
		check(pad_ie, 8'hff);
		rd(ADDR_PORT_DIRECTION, 8'hff);
		// Whole-port data and direction, with the serial links.
		for (int k = 0; k < 4; k++) begin
			m_data = 8'($random(seed));
			@(posedge clock);
			ext_lvl <= 8'($random(seed));
			ser_txd <= k[0];
			wr(ADDR_PORT_DIRECTION, m_dir);
			wr(ADDR_PORT_DATA, m_data);
			settle(3);
			check(pad_oe, ~m_dir);
			check(pad_out & ~m_dir, m_data & ~m_dir & ~{2'h0, ~ser_txd, 5'h0});
			check({7'h0, ser_rxd}, {7'h0, ext_lvl[6]});
			rd(ADDR_PORT_DATA, (m_data & ~m_dir) | (ext_lvl & m_dir));
		end
		// Feature writes touch one addressed pin each.
		for (int k = 0; k < 12; k++) begin
			code = 3'(k % 6);
			p = code < 3'h2 ? $unsigned($random(seed)) % 4 : 6 + $unsigned($random(seed)) % 2;
			wr(ADDR_PIN_FEATURE, {1'b0, 3'(p), code < 3'h2, code});
			if (code < 3'h2) m_hd[p] = code[0];
			else begin
				m_pu[p] = (code == 3'h3);
				m_pd[p] = (code == 3'h4);
				m_ie[p] = (code != 3'h5);
			end
			settle(1);
			check(pad_high_drive & 8'h0f, m_hd & 8'h0f);
			check(pad_pull_up & m_ie & 8'hc0, m_pu & m_ie & 8'hc0);
			check(pad_pull_down & m_ie & 8'hc0, m_pd & m_ie & 8'hc0);
			check(pad_ie & 8'hc0, m_ie & 8'hc0);
		end
		// Router grants under priority, all pins or none.
		for (int c = 0; c < 6; c++) begin
			@(posedge clock);
			periph_en <= EN_CASE[c];
			periph_do <= 48'({$random(seed), $random(seed)});
			settle(5);
			taken = 8'h00;
			oe_x = 8'h00;
			dout = 8'h00;
			g = 6'h00;
			for (int j = 0; j < 6; j++) begin
				if (EN_CASE[c][j] && (PINS[j*8+:8] & taken) == 8'h00) begin
					g[j] = 1'b1;
					taken |= PINS[j*8+:8];
					oe_x |= OUTS[j*8+:8] & PINS[j*8+:8];
					dout |= periph_do[j*8+:8] & OUTS[j*8+:8] & PINS[j*8+:8];
				end
			end
			rd(ADDR_PIN_STATE, taken);
			rd(ADDR_GRANT_STATUS, {2'h0, g});
			check(pad_oe & 8'hef, (oe_x | (~taken & ~m_dir)) & 8'hef);
			check(pad_out & oe_x & 8'hef, dout & 8'hef);
			check({7'h0, pad_oe[4]}, {7'h0, taken[4] ? oe_x[4] & ~pad_in[5] : ~m_dir[4]});
			for (int j = 0; j < 6; j++) begin
				check(periph_di[j*8+:8], g[j] ? pad_in & PINS[j*8+:8] : 8'h00);
			end
		end
		// Analog connects only the selected pins and leaves digital settings.
		for (int k = 0; k < 4; k++) begin
			@(posedge clock);
			periph_en <= 6'h00;
			conv_en <= k[0];
			comp_en <= ~k[0];
			converter_channel_select <= 3'($random(seed));
			converter_reference_select <= 3'($random(seed));
			converter_reference_ext <= k[1];
			settle(3);
			check(analog_connect, (8'h01 << converter_channel_select)
				| (k[1] ? 8'h01 << converter_reference_select : 8'h00));
			rd(ADDR_PORT_DIRECTION, m_dir);
			check(pad_oe, ~m_dir);
		end
		// Crystal oscillator takes its pins digitally, then as analog inputs.
		@(posedge clock);
		xosc_en <= 1'b1;
		xosc_pins <= 8'h02;
		periph_en <= 6'h01;
		conv_en <= 1'b0;
		settle(3);
		rd(ADDR_GRANT_STATUS, 8'h00);
		rd(ADDR_PIN_STATE, 8'h02);
		check(pad_oe, ~m_dir & 8'hfd);
		@(posedge clock);
		xosc_analog <= 1'b1;
		xosc_pins <= 8'h80;
		conv_en <= 1'b1;
		converter_channel_select <= 3'h2;
		settle(3);
		check(analog_connect, 8'h84);
		rd(ADDR_GRANT_STATUS, 8'h01);
		@(posedge clock);
		xosc_en <= 1'b0;
		periph_en <= 6'h00;
		conv_en <= 1'b0;
		comp_en <= 1'b0;
		settle(3);
		check(analog_connect, 8'h00);
		rd(4'h9, 8'h00);
		// A low clock enable freezes the registers against a write.
		@(posedge clock);
		clk_en <= 1'b0;
		wr(ADDR_PORT_DIRECTION, 8'h00);
		settle(1);
		check(pad_oe, ~m_dir);
		@(posedge clock);
		clk_en <= 1'b1;
		rd(ADDR_PORT_DIRECTION, m_dir);
		// Second reset in mid-run.
		@(posedge clock);
		rst_n <= 1'b0;
		settle(2);
		check(pad_oe, 8'h00);
		check(pad_ie, 8'hff);
		check(analog_connect, 8'h00);
		@(posedge clock);
		rst_n <= 1'b1;
		rd(ADDR_PORT_DIRECTION, 8'hff);
		results();
	end
endmodule : ipx_pin_router_test
